// ===== rtl/lirb_builder.sv
// Link incident record builder: register file, counter and payload sequencer
//
// How it works
// - No specific record: format 00h, length zero
// - Specific record: format is protocol type code
// - Common length 16 short, 64 long
// - Descriptor length always four
// - Specific length bytes, multiple of four, <=252 in header; sequencer ends the payload only up to 128
// - Emit four or sixteen common words
// - Unknown optional long words are zero
// - Unknown port type encoded as zero
// - Connected port chosen from topology
// - Unknown connected names zeroed
// - Fabric name from login, private loop zero
// - Port number field carries valid identifier
// - Transaction counter starts at one, increments
// - Counter never yields zero
// - Time stamp format 00h, 01h, 02h only
// - Unknown format leaves time stamp free
// - Incident names identify one link end
// - Qualifier byte zero, type code byte one
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module lirb_builder #(
    parameter int unsigned ADR_W = 8 // Wishbone byte address width
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    // Wishbone classic slave
    input  wire logic                    wb_cyc,
    input  wire logic                    wb_stb,
    input  wire logic                    wb_we,
    input  wire logic [ADR_W-1:0]        wb_adr,
    input  wire logic [3:0]              wb_sel,
    input  wire logic [31:0]             wb_dat_w,
    output logic      [31:0]             wb_dat_r,
    output logic                         wb_ack,
    // Incident from local port logic
    input  wire lirb_pkg::lirb_incident_t inc_data,
    input  wire logic                    inc_valid,
    output logic                         inc_ready,
    // Specific record words
    input  wire logic [31:0]             spec_data,
    input  wire logic                    spec_valid,
    output logic                         spec_ready,
    // Payload toward frame transmit path
    output lirb_pkg::lirb_word_t         tx_word,
    output logic                         tx_valid,
    input  wire logic                    tx_ready
);
    import lirb_pkg::*;

    // Refuse an address bus too narrow for the map
    // Sixteen words need four index bits above the byte lanes
    if (ADR_W < 6) begin : g_adr_chk
        $error("lirb_builder: ADR_W must be at least 6");
    end

    // Byte-lane merge of a write into a stored word
    // Unselected lanes keep their stored bytes
    function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_sel

    // Register storage and bus state
    logic [31:0]    regs_q [NUM_RW];       // Software-written words
    logic           ack_q;                 // Bus acknowledge
    logic [31:0]    rdat_q;                // Read data
    // Sequencer state
    lirb_state_t    state_q, state_d;      // Next word class to load
    logic [4:0]     idx_q, idx_d;          // Word index within a section
    lirb_incident_t inc_q;                 // Captured incident
    logic [31:0]    txn_q;                 // Next transaction ID
    logic [31:0]    rec_txn_q;             // ID of record in flight
    lirb_word_t     word_q, word_d;        // Output word register
    logic           valid_q, valid_d;      // Output word valid

    // Bus decode
    // Request seen only while no ack is out, so a held strobe
    // cannot be taken twice; ack then falls for one cycle
    wire            bus_req   = wb_cyc && wb_stb && !ack_q;
    wire [ADR_W-3:0] reg_idx  = wb_adr[ADR_W-1:2];
    wire            idx_rw    = reg_idx < (ADR_W-2)'(NUM_RW);
    wire            idx_txn   = reg_idx == (ADR_W-2)'(REG_TXN);
    wire            wr_hit    = bus_req && wb_we && idx_rw;

    // Control fields
    wire [31:0]     ctrl      = regs_q[REG_CTRL];
    wire            long_fmt  = ctrl[CTRL_LONG];
    wire [1:0]      topo      = ctrl[CTRL_TOPO_LSB +: 2];
    wire [7:0]      port_type = ctrl[CTRL_PTYPE_LSB +: 8];   // zero when unknown
    wire [7:0]      tsf_raw   = ctrl[CTRL_TSF_LSB +: 8];
    wire            busy      = state_q != LIRB_IDLE;

    // Specific record: protocol code and byte length
    // Low two length bits ignored: only whole words travel
    // A length without a protocol code is dropped as a whole
    wire [7:0]      upper_layer_protocol       = regs_q[REG_SPEC][SPEC_ULP_LSB +: 8];
    wire [7:0]      len_raw   = {regs_q[REG_SPEC][SPEC_LEN_LSB + 2 +: 6], 2'b00};
    wire            spec_on   = (len_raw != 8'h00) && (upper_layer_protocol != FMT_COMMON);
    wire [7:0]      spec_len  = spec_on ? len_raw : 8'h00;
    wire [7:0]      rec_fmt   = spec_on ? upper_layer_protocol : FMT_COMMON;
    wire [5:0]      spec_wds  = spec_len[7:2];

    // Common record length and word count
    // Word count follows the length field, bytes over four
    wire [7:0]      clen      = long_fmt ? CLEN_LONG : CLEN_SHORT;
    wire [4:0]      cwords    = long_fmt ? WORDS_LONG : WORDS_SHORT;

    // Names held by software
    // Lower index holds the upper half of each name
    wire [63:0]     inc_pn    = {regs_q[REG_INC_PN], regs_q[REG_INC_PN+1]};
    wire [63:0]     inc_nn    = {regs_q[REG_INC_NN], regs_q[REG_INC_NN+1]};
    wire [63:0]     att_pn    = {regs_q[REG_ATT_PN], regs_q[REG_ATT_PN+1]};
    wire [63:0]     att_nn    = {regs_q[REG_ATT_NN], regs_q[REG_ATT_NN+1]};
    wire [63:0]     fab_raw   = {regs_q[REG_FAB], regs_q[REG_FAB+1]};
    wire [63:0]     ts_raw    = {regs_q[REG_TS], regs_q[REG_TS+1]};

    // Private loop and loop-to-fabric ports report the incident's own partner, others the attached port
    // Unknown names go out as zero rather than stale data
    wire            use_assoc = (topo == TOPO_PRIV_LOOP) || (topo == TOPO_LOOP_FAB);
    wire            con_pn_ok = use_assoc ? inc_q.assoc_pn_known : ctrl[CTRL_ATT_PN_OK];
    wire            con_nn_ok = use_assoc ? inc_q.assoc_nn_known : ctrl[CTRL_ATT_NN_OK];
    wire [63:0]     con_pn    = !con_pn_ok ? 64'h0 :
                                use_assoc ? inc_q.assoc_pn : att_pn;
    wire [63:0]     con_nn    = !con_nn_ok ? 64'h0 :
                                use_assoc ? inc_q.assoc_nn : att_nn;

    // Fabric name only after login and never on a private loop
    // Login flag alone is not enough on a private loop
    wire            fab_ok    = ctrl[CTRL_FAB_OK] && (topo != TOPO_PRIV_LOOP);
    wire [63:0]     fab_name  = fab_ok ? fab_raw : 64'h0;

    // Reserved formats are sent as unknown; unknown time stamp sent as zero
    // Receiver ignores the stamp at format zero; zero keeps it tidy
    wire            tsf_legal = (tsf_raw == TSF_SERVER) || (tsf_raw == TSF_CLK_SYNC);
    wire [7:0]      tsf       = tsf_legal ? tsf_raw : TSF_UNKNOWN;
    wire [63:0]     ts_val    = tsf_legal ? ts_raw : 64'h0;

    // Payload header and descriptor words
    // Descriptor upper byte carries the qualifier, next the code
    wire [31:0]     hdr_word  = {rec_fmt, clen, DLEN, spec_len};
    wire [31:0]     desc_word = {inc_q.qualifier, 1'b0, inc_q.type_code, 16'h0};

    // Counter advance skips zero on wrap
    // Zero stands for an unknown identifier, so it is never issued
    wire [31:0]     txn_inc   = txn_q + 32'h1;
    wire [31:0]     txn_next  = (txn_inc == 32'h0) ? TXN_FIRST : txn_inc;

    // Common record word by index
    // Short record uses indices 0 to 3 only
    function automatic logic [31:0] common_word(input logic [3:0] i,
                                               input logic [63:0] ipn,
                                               input logic [63:0] inn,
                                               input logic [63:0] cpn,
                                               input logic [63:0] cnn,
                                               input logic [63:0] fab,
                                               input logic [63:0] ts,
                                               input logic [7:0]  ptype,
                                               input logic [7:0]  fmt,
                                               input logic [31:0] pnum,
                                               input logic [31:0] txn);
        logic [31:0] w;
        case (i)
            4'h0:    w = ipn[63:32];
            4'h1:    w = ipn[31:0];
            4'h2:    w = inn[63:32];
            4'h3:    w = inn[31:0];
            4'h4:    w = {ptype, 24'h0};
            4'h5:    w = cpn[63:32];
            4'h6:    w = cpn[31:0];
            4'h7:    w = cnn[63:32];
            4'h8:    w = cnn[31:0];
            4'h9:    w = fab[63:32];
            4'ha:    w = fab[31:0];
            4'hb:    w = pnum;
            4'hc:    w = txn;
            4'hd:    w = {24'h0, fmt};
            4'he:    w = ts[63:32];
            4'hf:    w = ts[31:0];
            default: w = 32'h0;
        endcase
        return w;
    endfunction : common_word

    // Current common word
    wire [31:0]     cw        = common_word(idx_q[3:0], inc_pn, inc_nn, con_pn, con_nn,
                                            fab_name, ts_val, port_type, tsf,
                                            regs_q[REG_PORT_NUM], rec_txn_q);

    // Handshakes
    // Output slot free when empty or being taken this edge
    // New incident only while the sequencer is idle
    wire            load_ok   = !valid_q || tx_ready;
    wire            take_inc  = inc_valid && !busy;
    assign inc_ready  = !busy;
    assign spec_ready = (state_q == LIRB_SPEC) && load_ok;
    assign tx_word    = word_q;
    assign tx_valid   = valid_q;
    assign wb_ack     = ack_q;
    assign wb_dat_r   = rdat_q;

    // Read multiplexer
    // Busy bit overlays the stored control word
    // Unmapped indices read as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (idx_txn) begin
            rd_mux = txn_q;
        end else if (idx_rw) begin
            rd_mux = regs_q[reg_idx[3:0]];
            if (reg_idx[3:0] == 4'(REG_CTRL)) begin
                rd_mux[CTRL_BUSY] = busy;
            end
        end
    end

    // Register writes
    // Writes land at the request edge, the same edge that raises ack
    // Counter index is read only, so writes there are dropped
    for (genvar r = 0; r < NUM_RW; r++) begin : g_regs
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                regs_q[r] <= RST_WORD;
            end else if (wr_hit && (reg_idx[3:0] == 4'(r))) begin
                regs_q[r] <= merge_sel(regs_q[r], wb_dat_w, wb_sel);
            end
        end
    end

    // Bus answer, one cycle after the request
    // Read data held until the next read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q  <= 1'b0;
            rdat_q <= RST_WORD;
        end else begin
            ack_q  <= bus_req;
            rdat_q <= (bus_req && !wb_we) ? rd_mux : rdat_q;
        end
    end

    // Sequencer next state and output word
    // Word is kept unless the sink takes it
    // Registers are read live; software leaves them still meanwhile
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        word_d  = word_q;
        valid_d = valid_q && !tx_ready;
        case (state_q)
            // Wait for an incident
            LIRB_IDLE: begin
                if (take_inc) begin
                    state_d = LIRB_HDR;
                end
            end
            // Lengths and format word
            LIRB_HDR: begin
                if (load_ok) begin
                    word_d  = '{data: hdr_word, last: 1'b0};
                    valid_d = 1'b1;
                    idx_d   = 5'h0;
                    state_d = LIRB_COMMON;
                end
            end
            // Four or sixteen common words
            LIRB_COMMON: begin
                if (load_ok) begin
                    word_d  = '{data: cw, last: 1'b0};
                    valid_d = 1'b1;
                    idx_d   = idx_q + 5'h1;
                    if (idx_q == cwords - 5'h1) begin
                        state_d = LIRB_DESC;
                    end
                end
            end
            // Descriptor word
            // Ends the payload when no specific record follows
            LIRB_DESC: begin
                if (load_ok) begin
                    word_d  = '{data: desc_word, last: spec_wds == 6'h0};
                    valid_d = 1'b1;
                    idx_d   = 5'h0;
                    state_d = (spec_wds == 6'h0) ? LIRB_IDLE : LIRB_SPEC;
                end
            end
            // Specific record words passed through
            // Waits on the source as well as the sink
            LIRB_SPEC: begin
                if (load_ok && spec_valid) begin
                    word_d  = '{data: spec_data, last: {1'b0, idx_q} == spec_wds - 6'h1};
                    valid_d = 1'b1;
                    idx_d   = idx_q + 5'h1;
                    if ({1'b0, idx_q} == spec_wds - 6'h1) begin
                        state_d = LIRB_IDLE;
                    end
                end
            end
            default: begin
                state_d = LIRB_IDLE;
            end
        endcase
    end

    // Sequencer registers
    // Output word and valid reset empty
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= LIRB_IDLE;
            idx_q   <= 5'h0;
            word_q  <= '0;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
            word_q  <= word_d;
            valid_q <= valid_d;
        end
    end

    // Incident capture and transaction numbering
    // Record keeps its own ID while the counter moves on
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            inc_q     <= '0;
            txn_q     <= TXN_FIRST;
            rec_txn_q <= RST_WORD;
        end else if (take_inc) begin
            inc_q     <= inc_data;
            rec_txn_q <= txn_q;
            txn_q     <= txn_next;
        end
    end

endmodule : lirb_builder

// ===== rtl/lirb_pkg.sv
// Package for the link incident record builder: map, fields, codes, carriers
package lirb_pkg;

    // Register word indices; byte address is four times the index
    localparam int unsigned REG_CTRL     = 0;  // Control and busy
    localparam int unsigned REG_SPEC     = 1;  // Specific record protocol and length
    localparam int unsigned REG_INC_PN   = 2;  // Incident port name, 2 words
    localparam int unsigned REG_INC_NN   = 4;  // Incident node name, 2 words
    localparam int unsigned REG_ATT_PN   = 6;  // Attached fabric/loop port name, 2 words
    localparam int unsigned REG_ATT_NN   = 8;  // Attached fabric/loop node name, 2 words
    localparam int unsigned REG_FAB      = 10; // Fabric or switch name, 2 words
    localparam int unsigned REG_PORT_NUM = 12; // Incident port number
    localparam int unsigned REG_TS       = 13; // Time stamp, 2 words
    localparam int unsigned REG_TXN      = 15; // Next transaction ID, read only
    localparam int unsigned NUM_RW       = 15; // Words held in flip-flops
    localparam int unsigned NUM_REGS     = 16; // Mapped words

    // Control field positions
    localparam int unsigned CTRL_LONG      = 0;  // Long common record
    localparam int unsigned CTRL_ATT_PN_OK = 1;  // Attached port name known
    localparam int unsigned CTRL_ATT_NN_OK = 2;  // Attached node name known
    localparam int unsigned CTRL_FAB_OK    = 3;  // Fabric login done
    localparam int unsigned CTRL_TOPO_LSB  = 4;  // Topology, 2 bits
    localparam int unsigned CTRL_PTYPE_LSB = 8;  // Incident port type, 8 bits
    localparam int unsigned CTRL_TSF_LSB   = 16; // Time stamp format, 8 bits
    localparam int unsigned CTRL_BUSY      = 31; // Read-only busy
    localparam int unsigned SPEC_LEN_LSB   = 0;  // Specific length, 8 bits
    localparam int unsigned SPEC_ULP_LSB   = 8;  // Upper layer protocol, 8 bits

    // Topology of the incident port
    localparam logic [1:0] TOPO_PRIV_LOOP = 2'h0;
    localparam logic [1:0] TOPO_PUB_LOOP  = 2'h1;
    localparam logic [1:0] TOPO_FABRIC    = 2'h2;
    localparam logic [1:0] TOPO_LOOP_FAB  = 2'h3;

    // Payload constants
    localparam logic [7:0]  FMT_COMMON    = 8'h00;
    localparam logic [7:0]  CLEN_SHORT    = 8'h10;
    localparam logic [7:0]  CLEN_LONG     = 8'h40;
    localparam logic [7:0]  DLEN          = 8'h04;
    localparam logic [4:0]  WORDS_SHORT   = 5'h04;
    localparam logic [4:0]  WORDS_LONG    = 5'h10;
    localparam logic [7:0]  TSF_UNKNOWN   = 8'h00;
    localparam logic [7:0]  TSF_SERVER    = 8'h01;
    localparam logic [7:0]  TSF_CLK_SYNC  = 8'h02;
    localparam logic [31:0] TXN_FIRST     = 32'h0000_0001;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;

    // Sequencer states
    typedef enum logic [2:0] {
        LIRB_IDLE, LIRB_HDR, LIRB_COMMON, LIRB_DESC, LIRB_SPEC
    } lirb_state_t;

    // One incident from the local port logic
    typedef struct packed {
        logic [7:0]  qualifier;      // incident_qualifier byte
        logic [6:0]  type_code;      // incident_type_code
        logic [63:0] assoc_pn;       // Port name tied to the incident
        logic [63:0] assoc_nn;       // Node name tied to the incident
        logic        assoc_pn_known; // assoc_pn is valid
        logic        assoc_nn_known; // assoc_nn is valid
    } lirb_incident_t;

    // Outgoing payload word
    typedef struct packed {
        logic [31:0] data; // Payload word
        logic        last; // Final word of the payload
    } lirb_word_t;

endpackage : lirb_pkg

// ===== verif/lirb_sink.sv
// Payload sink model: the remote port that takes report words, with periodic stalls
`timescale 1ns/1ns
module lirb_sink (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Payload stream
    input  wire logic tx_valid,
    output logic      tx_ready
);
    logic [1:0] phase_q; // Stall pattern phase

    // Ready three cycles of four, low in the cycle after phase two
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q  <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            phase_q  <= phase_q + 2'h1;
            tx_ready <= (phase_q != 2'h2);
        end
    end
endmodule : lirb_sink

// ===== verif/lirb_builder_props.sv
// Checker for the record builder ports: bus handshake, header fields, output hold
`timescale 1ns/1ns
module lirb_builder_props (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // Bus handshake
    input  wire logic                 wb_cyc,
    input  wire logic                 wb_stb,
    input  wire logic                 wb_ack,
    // Incident and payload
    input  wire logic                 inc_valid,
    input  wire logic                 inc_ready,
    input  wire logic                 spec_ready,
    input  wire lirb_pkg::lirb_word_t tx_word,
    input  wire logic                 tx_valid,
    input  wire logic                 tx_ready
);
    import lirb_pkg::*;
    logic req_w; // Bus request present
    assign req_w = wb_cyc && wb_stb;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Incident taken into an empty slot, header word valid at the second edge after
    sequence hdr_s;
        inc_valid && inc_ready && !tx_valid ##2 tx_valid;
    endsequence
    a_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    a_ack_answers: assert property (req_w && !wb_ack |=> wb_ack)
        else $error("no ack one cycle after request");
    a_ack_cause: assert property (wb_ack |-> $past(req_w))
        else $error("ack without request");
    a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
        else $error("payload word changed before acceptance");
    a_hdr_dlen: assert property (hdr_s |-> tx_word.data[15:8] == 8'h04)
        else $error("descriptor length not four");
    a_hdr_clen: assert property (hdr_s |-> tx_word.data[23:16] inside {8'h10, 8'h40})
        else $error("common length not 16 or 64");
    a_hdr_format: assert property (hdr_s |->
        (tx_word.data[7:0] == 8'h00) == (tx_word.data[31:24] == 8'h00))
        else $error("format and specific length disagree");
    a_hdr_slen: assert property (hdr_s |-> tx_word.data[1:0] == 2'h0 && !tx_word.last)
        else $error("specific length not a multiple of four");
    a_busy_record: assert property (inc_valid && inc_ready |=> !inc_ready [*4])
        else $error("new incident taken inside a record");
    a_spec_busy: assert property (spec_ready |-> !inc_ready)
        else $error("specific words asked while idle");
endmodule : lirb_builder_props

bind lirb_builder lirb_builder_props u_props (.ref_clk(ref_clk), .arst_n(arst_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack), .inc_valid(inc_valid),
    .inc_ready(inc_ready), .spec_ready(spec_ready), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

// ===== verif/tb_link_incident_record_builder.sv
// Testbench for the record builder: register set-up over the bus, records compared word by word
`timescale 1ns/1ns
module tb_link_incident_record_builder;
    import lirb_pkg::*;
    logic ref_clk = 1'b0, arst_n = 1'b0;               // Clock and reset
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;   // Bus request
    logic [7:0] wb_adr = 8'h00;                        // Byte address
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r;           // Bus data
    logic wb_ack, inc_valid = 1'b0, inc_ready;         // Handshakes
    logic spec_valid = 1'b1, spec_ready, tx_valid, tx_ready;
    logic [31:0] spec_data = 32'ha000_0000;            // Specific record source
    lirb_incident_t inc = '0;                          // Incident to report
    lirb_incident_t inc_data = '0;
    lirb_word_t tx_word;
    logic [32:0] exp_q[$], got_q[$];                  // Words as {data, last}
    int fail_count = 0, samples_checked = 0;
    lirb_builder DUT (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .inc_data(inc_data), .inc_valid(inc_valid), .inc_ready(inc_ready),
        .spec_data(spec_data), .spec_valid(spec_valid), .spec_ready(spec_ready),
        .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready));
    lirb_sink u_sink (.ref_clk(ref_clk), .arst_n(arst_n), .tx_valid(tx_valid),
        .tx_ready(tx_ready));
    // Clock, 100 ns period
    always #50 ref_clk = ~ref_clk;
    // Collect accepted payload words
    always @(posedge ref_clk) if (arst_n && tx_valid && tx_ready)
        got_q.push_back({tx_word.data, tx_word.last});
    // Next specific word after each one taken
    always @(posedge ref_clk) if (spec_valid && spec_ready) spec_data <= spec_data + 32'h1;
    function automatic logic [31:0] rv(input int i);
        return 32'hc0de_0000 | 32'(i);
    endfunction : rv
    function automatic logic [63:0] rv64(input int i);
        return {rv(i), rv(i + 1)};
    endfunction : rv64
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One classic bus cycle, held until ack is sampled
    task automatic wb(input logic we, input int idx, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= 8'(idx * 4); wb_dat_w <= d;
        do begin @(posedge ref_clk); n++; end while (wb_ack !== 1'b1 && n < 20);
        q = wb_dat_r;
        chk("wb_ack", 33'h1, {32'h0, wb_ack});
        wb_cyc <= 1'b0; wb_stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    task automatic wr(input int idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input int idx, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 32'h0, q);
        chk("register", {e, 1'b0}, {q, 1'b0});
    endtask : rd
    task automatic ew(input logic [31:0] w);
        exp_q.push_back({w, 1'b0});
    endtask : ew
    task automatic e64(input logic [63:0] v);
        ew(v[63:32]); ew(v[31:0]);
    endtask : e64
    // Long common record body in fixed word order
    task automatic elong(input logic [7:0] pt, input logic [63:0] cpn, input logic [63:0] cnn,
                         input logic [63:0] fab, input logic [31:0] txn, input logic [7:0] fmt,
                         input logic [63:0] ts);
        e64(rv64(2)); e64(rv64(4)); ew({pt, 24'h0}); e64(cpn); e64(cnn); e64(fab);
        ew(rv(12)); ew(txn); ew({24'h0, fmt}); e64(ts);
    endtask : elong
    // Raise an incident, wait for its last word, compare the whole payload
    task automatic fire();
        int n = 0;
        exp_q[exp_q.size() - 1][0] = 1'b1;
        got_q.delete();
        @(posedge ref_clk);
        inc_data <= inc; inc_valid <= 1'b1;
        do begin @(posedge ref_clk); n++; end while (inc_ready !== 1'b1 && n < 50);
        inc_valid <= 1'b0;
        n = 0;
        while ((got_q.size() == 0 || got_q[$][0] !== 1'b1) && n < 400) begin
            @(posedge ref_clk); n++;
        end
        chk("word count", 33'(exp_q.size()), 33'(got_q.size()));
        foreach (exp_q[i]) chk("payload word", exp_q[i], got_q[i]);
        exp_q.delete();
    endtask : fire
    // Main sequence
    initial begin
        inc.qualifier = 8'h24; inc.type_code = 7'h05;
        inc.assoc_pn = 64'hbeef_0001_beef_0002; inc.assoc_nn = 64'hbeef_0003_beef_0004;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(REG_TXN, TXN_FIRST);
        rd(20, 32'h0);
        for (int i = 2; i < 15; i++) wr(i, rv(i));
        rd(REG_PORT_NUM, rv(12));
        // Short record, no specific record
        wr(REG_CTRL, 32'h0);
        ew({FMT_COMMON, CLEN_SHORT, DLEN, 8'h00}); e64(rv64(2)); e64(rv64(4)); ew(32'h2405_0000);
        fire();
        rd(REG_TXN, 32'h2);
        wr(REG_TXN, 32'h0);
        rd(REG_TXN, 32'h2);
        // Fabric port, server time stamp
        wr(REG_CTRL, 32'h0001_112f);
        ew({FMT_COMMON, CLEN_LONG, DLEN, 8'h00});
        elong(8'h11, rv64(6), rv64(8), rv64(10), 32'h2, TSF_SERVER, rv64(13));
        ew(32'h2405_0000);
        fire();
        // Private loop with specific record, node name unknown
        wr(REG_CTRL, 32'h0002_000f);
        wr(REG_SPEC, 32'h0000_0808);
        inc.assoc_pn_known = 1'b1;
        ew({8'h08, CLEN_LONG, DLEN, 8'h08});
        elong(8'h00, inc.assoc_pn, 64'h0, 64'h0, 32'h3, TSF_CLK_SYNC, rv64(13));
        ew(32'h2405_0000); ew(32'ha000_0000); ew(32'ha000_0001);
        fire();
        // Public loop, names unknown, reserved format, protocol zero
        wr(REG_CTRL, 32'h0005_0019);
        wr(REG_SPEC, 32'h0000_0008);
        ew({FMT_COMMON, CLEN_LONG, DLEN, 8'h00});
        elong(8'h00, 64'h0, 64'h0, rv64(10), 32'h4, TSF_UNKNOWN, 64'h0);
        ew(32'h2405_0000);
        fire();
        rd(REG_TXN, 32'h5);
        // Loop-to-fabric port, both incident partner names known
        wr(REG_CTRL, 32'h0000_003d);
        rd(REG_CTRL, 32'h0000_003d);
        inc.assoc_nn_known = 1'b1;
        ew({FMT_COMMON, CLEN_LONG, DLEN, 8'h00});
        elong(8'h00, inc.assoc_pn, inc.assoc_nn, rv64(10), 32'h5, TSF_UNKNOWN, 64'h0);
        ew(32'h2405_0000);
        fire();
        rd(REG_TXN, 32'h6);
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end
endmodule : tb_link_incident_record_builder
